// file: inc/lrf_regs.vh
// register map, field positions, reset values and timing counts of the
// rotation and firing controller; included by bare name, definitions only
`ifndef LRF_REGS_VH
`define LRF_REGS_VH

// apb byte offsets
`define LRF_ADDR_CTRL       8'h00
`define LRF_ADDR_RET_MODE   8'h04
`define LRF_ADDR_SYNC_ANGLE 8'h08
`define LRF_ADDR_STATUS     8'h0C
`define LRF_ADDR_PHASE_ERR  8'h10

// control register fields
`define LRF_CTRL_SPIN       0
`define LRF_CTRL_TRIG_TIME  1
`define LRF_CTRL_FILTER     2
`define LRF_CTRL_NONLIN     3
`define LRF_CTRL_STANDBY    4
`define LRF_CTRL_SRC_PTP    5
`define LRF_CTRL_LOCK_EN    6
`define LRF_CTRL_RESET      7'h00

// return mode codes
`define LRF_RET_LAST        3'h0
`define LRF_RET_STRONG      3'h1
`define LRF_RET_FIRST       3'h2
`define LRF_RET_LAST_STRONG 3'h3
`define LRF_RET_LAST_FIRST  3'h4
`define LRF_RET_FIRST_STRONG 3'h5
`define LRF_RET_RESET       3'h3

// azimuth in encoder ticks of 0.09 degree, 4000 per turn
`define LRF_AZ_TICKS        13'h0FA0
`define LRF_AZ_HALF         13'h07D0
`define LRF_SYNC_RESET      12'h000
`define LRF_LOCK_TOL        13'h0004

// spin rates reported in rpm
`define LRF_RPM_LOW         11'h258
`define LRF_RPM_HIGH        11'h4B0

// firing steps in encoder ticks: 0.18 deg at 10 Hz, 0.36 deg at 20 Hz
`define LRF_STEP_10HZ       3'h2
`define LRF_STEP_20HZ       3'h4

// timing
`define LRF_CLK_PERIOD_NS   100
`define LRF_FIRE_PERIOD_NS  50000
`define LRF_FIRE_CYC        (`LRF_FIRE_PERIOD_NS / `LRF_CLK_PERIOD_NS)
`define LRF_SEC_CYC         10000000

`endif

// file: hdl/lrf_sync.v
// two flip-flop synchroniser for a bundle of asynchronous levels
// assumes each bit is a slow level or a pulse of several clock periods
`timescale 1ns/1ps
module lrf_sync
#(
	parameter WIDTH = 7
)
(
	// clock and reset
	input  wire             clk_in,
	input  wire             rstn_in,
	// asynchronous levels and their synchronised copies
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta; // first stage, read only by the second

	// two stages, cleared under reset
	always @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			meta     <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end
		else
		begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

endmodule

// file: hdl/lrf_top.v
// rotor spin, phase lock, laser firing scheduler and point post-processing
// assumes an apb master on REF_CLK_IN, encoder and timing pins asynchronous,
// point stream from same-clock logic
`timescale 1ns/1ps
`include "lrf_regs.vh"

module lrf_top
#(
	parameter SEC_CYCLES = `LRF_SEC_CYC
)
(
	// clock and reset
	input  wire        REF_CLK_IN,
	input  wire        RSTN_IN,
	// apb slave
	input  wire        PSEL_IN,
	input  wire        PENABLE_IN,
	input  wire        PWRITE_IN,
	input  wire [7:0]  PADDR_IN,
	input  wire [31:0] PWDATA_IN,
	output reg  [31:0] PRDATA_OUT,
	output reg         PREADY_OUT,
	output reg         PSLVERR_OUT,
	// timing pins
	input  wire        PPS_IN,
	input  wire        GPS_LOCK_IN,
	input  wire        PTP_SEC_IN,
	input  wire        PTP_LOCK_IN,
	// rotor encoder and motor driver
	input  wire        ENC_TICK_IN,
	input  wire        ENC_INDEX_IN,
	input  wire        MOTOR_AT_SPEED_IN,
	output reg         MOTOR_EN_OUT,
	output reg         MOTOR_FAST_OUT,
	output reg  [12:0] MOTOR_PHASE_ERR_OUT,
	output reg         MOTOR_PHASE_STB_OUT,
	// laser trigger
	output reg         FIRE_OUT,
	// point stream in
	input  wire        PT_VALID_IN,
	input  wire [15:0] PT_DIST_IN,
	input  wire [7:0]  PT_REFL_IN,
	input  wire        PT_MIXED_IN,
	// point stream out
	output reg         PT_VALID_OUT,
	output reg  [15:0] PT_DIST_OUT,
	output reg  [7:0]  PT_REFL_OUT,
	output reg  [2:0]  PT_MODE_OUT
);

	// run states
	localparam ST_STOP  = 2'h0; // standby, motor off
	localparam ST_SPIN  = 2'h1; // motor on, waiting for speed
	localparam ST_RUN   = 2'h2; // at speed, firing

	// last counts, cut to their counter widths on purpose
	localparam integer FIRE_LAST_I = `LRF_FIRE_CYC - 1;
	localparam integer SEC_LAST_I  = SEC_CYCLES - 1;
	localparam [8:0]   FIRE_LAST   = FIRE_LAST_I[8:0];
	localparam [23:0]  SEC_LAST    = SEC_LAST_I[23:0];

	// piecewise curve, steep at low reflectivity
	function [7:0] refl_curve;
		input [7:0] x;
		begin
			if (x < 8'h20)
				refl_curve = {x[5:0], 2'h0};
			else if (x < 8'h60)
				refl_curve = 8'h80 + (x - 8'h20);
			else
				refl_curve = 8'hC0 + ((x - 8'h60) >> 2);
		end
	endfunction

	// firing step in encoder ticks for a spin setting
	function [2:0] fire_step;
		input fast;
		begin
			fire_step = fast ? `LRF_STEP_20HZ : `LRF_STEP_10HZ;
		end
	endfunction

	// synchronised pins
	wire [6:0] pins_sync;
	wire       pps_s     = pins_sync[0];
	wire       gps_lock  = pins_sync[1];
	wire       ptp_sec_s = pins_sync[2];
	wire       ptp_lock  = pins_sync[3];
	wire       tick_s    = pins_sync[4];
	wire       index_s   = pins_sync[5];
	wire       at_speed  = pins_sync[6];

	lrf_sync #(.WIDTH(7)) u_sync
	(
		.clk_in   (REF_CLK_IN),
		.rstn_in  (RSTN_IN),
		.async_in ({MOTOR_AT_SPEED_IN, ENC_INDEX_IN, ENC_TICK_IN,
		            PTP_LOCK_IN, PTP_SEC_IN, GPS_LOCK_IN, PPS_IN}),
		.sync_out (pins_sync)
	);

	// registers
	reg [6:0]  ctrl;        // control bits
	reg [2:0]  ret_mode;    // return mode code
	reg [11:0] sync_angle;  // lock azimuth, 0.09 degree units
	reg [1:0]  state;       // run state
	reg        phase_lock;  // phase within tolerance
	reg [1:0]  sec_src;     // 0 internal, 1 gps, 2 ptp
	reg [12:0] azimuth;     // encoder position
	reg [12:0] phase_err;   // last measured error
	reg [2:0]  step_cnt;    // ticks since last angle fire
	reg [8:0]  fire_cnt;    // time-based period counter
	reg [23:0] sec_cnt;     // internal 1 Hz divider
	reg        int_tick;    // internal 1 Hz level
	reg        pps_d;       // edge detect copies
	reg        ptp_d;
	reg        tick_d;
	reg        index_d;
	reg        int_d;

	wire apb_wr = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN;
	wire spin_fast = ctrl[`LRF_CTRL_SPIN];

	// edges
	wire pps_rise  = pps_s & ~pps_d;
	wire ptp_rise  = ptp_sec_s & ~ptp_d;
	wire tick_rise = tick_s & ~tick_d;
	wire idx_rise  = index_s & ~index_d;
	wire int_rise  = int_tick & ~int_d;

	// full-second source: selected clock if locked, else internal tick
	reg       full_sec;
	reg [1:0] next_src;
	always @*
	begin
		if (!ctrl[`LRF_CTRL_SRC_PTP] && gps_lock)
		begin
			full_sec = pps_rise;
			next_src = 2'h1;
		end
		else if (ctrl[`LRF_CTRL_SRC_PTP] && ptp_lock)
		begin
			full_sec = ptp_rise;
			next_src = 2'h2;
		end
		else
		begin
			full_sec = int_rise;
			next_src = 2'h0;
		end
	end

	// wrapped phase error, azimuth minus target
	reg [12:0] next_err;
	always @*
	begin
		next_err = azimuth - {1'b0, sync_angle};
		if (!next_err[12] && next_err >= `LRF_AZ_HALF)
			next_err = next_err - `LRF_AZ_TICKS;
		else if (next_err[12] && (13'h0 - next_err) > `LRF_AZ_HALF)
			next_err = next_err + `LRF_AZ_TICKS;
	end

	wire [12:0] err_abs = next_err[12] ? (13'h0 - next_err) : next_err;

	// apb register writes
	always @(posedge REF_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			ctrl       <= `LRF_CTRL_RESET;
			ret_mode   <= `LRF_RET_RESET;
			sync_angle <= `LRF_SYNC_RESET;
		end
		else if (apb_wr)
		begin
			case (PADDR_IN)
				`LRF_ADDR_CTRL:
					ctrl <= PWDATA_IN[6:0];
				`LRF_ADDR_RET_MODE:
					// codes above five are ignored
					if (PWDATA_IN[2:0] <= `LRF_RET_FIRST_STRONG)
						ret_mode <= PWDATA_IN[2:0];
				`LRF_ADDR_SYNC_ANGLE:
					// only angles below a full turn are taken
					if (PWDATA_IN[12:0] < `LRF_AZ_TICKS)
						sync_angle <= PWDATA_IN[11:0];
				default:
					ctrl <= ctrl;
			endcase
		end
	end

	// apb answer, ready in the first access cycle
	always @(posedge REF_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			PRDATA_OUT  <= 32'h0;
			PREADY_OUT  <= 1'b0;
			PSLVERR_OUT <= 1'b0;
		end
		else
		begin
			PREADY_OUT  <= PSEL_IN & ~PENABLE_IN;
			PSLVERR_OUT <= 1'b0;
			PRDATA_OUT  <= 32'h0;
			if (PSEL_IN && !PENABLE_IN)
			begin
				case (PADDR_IN)
					`LRF_ADDR_CTRL:
						PRDATA_OUT <= {25'h0, ctrl};
					`LRF_ADDR_RET_MODE:
						PRDATA_OUT <= {29'h0, ret_mode};
					`LRF_ADDR_SYNC_ANGLE:
						PRDATA_OUT <= {20'h0, sync_angle};
					`LRF_ADDR_STATUS:
						// rpm, run state, lock and source
						PRDATA_OUT <= {11'h0, sec_src, phase_lock, state,
						               5'h0, spin_fast ? `LRF_RPM_HIGH
						                               : `LRF_RPM_LOW};
					`LRF_ADDR_PHASE_ERR:
						PRDATA_OUT <= {19'h0, phase_err};
					default:
						// unmapped: error answer
						PSLVERR_OUT <= 1'b1;
				endcase
			end
		end
	end

	// edge copies, internal second divider, azimuth counter
	always @(posedge REF_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			pps_d    <= 1'b0;
			ptp_d    <= 1'b0;
			tick_d   <= 1'b0;
			index_d  <= 1'b0;
			int_d    <= 1'b0;
			int_tick <= 1'b0;
			sec_cnt  <= 24'h0;
			azimuth  <= 13'h0;
			sec_src  <= 2'h0;
		end
		else
		begin
			pps_d   <= pps_s;
			ptp_d   <= ptp_sec_s;
			tick_d  <= tick_s;
			index_d <= index_s;
			int_d   <= int_tick;
			sec_src <= next_src;
			// 1 Hz square wave, rising at each counter wrap
			if (sec_cnt == SEC_LAST)
			begin
				sec_cnt  <= 24'h0;
				int_tick <= 1'b1;
			end
			else
			begin
				sec_cnt <= sec_cnt + 24'h1;
				if (sec_cnt == {1'b0, SEC_LAST[23:1]})
					int_tick <= 1'b0;
			end
			// index zeroes the azimuth
			if (idx_rise)
				azimuth <= 13'h0;
			else if (tick_rise)
				azimuth <= (azimuth == `LRF_AZ_TICKS - 13'h1) ? 13'h0
				                                             : azimuth + 13'h1;
		end
	end

	// run state, motor drive and phase lock
	always @(posedge REF_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			state               <= ST_STOP;
			MOTOR_EN_OUT        <= 1'b0;
			MOTOR_FAST_OUT      <= 1'b0;
			phase_lock          <= 1'b0;
			phase_err           <= 13'h0;
			MOTOR_PHASE_ERR_OUT <= 13'h0;
			MOTOR_PHASE_STB_OUT <= 1'b0;
		end
		else
		begin
			MOTOR_FAST_OUT      <= spin_fast;
			MOTOR_PHASE_STB_OUT <= 1'b0;
			case (state)
				ST_STOP:
				begin
					MOTOR_EN_OUT <= 1'b0;
					phase_lock   <= 1'b0;
					if (!ctrl[`LRF_CTRL_STANDBY])
						state <= ST_SPIN;
				end
				ST_SPIN:
				begin
					MOTOR_EN_OUT <= 1'b1;
					phase_lock   <= 1'b0;
					if (ctrl[`LRF_CTRL_STANDBY])
						state <= ST_STOP;
					else if (at_speed)
						state <= ST_RUN;
				end
				ST_RUN:
				begin
					MOTOR_EN_OUT <= 1'b1;
					if (ctrl[`LRF_CTRL_STANDBY])
						state <= ST_STOP;
					else if (!at_speed)
						state <= ST_SPIN;
					else if (full_sec && ctrl[`LRF_CTRL_LOCK_EN])
					begin
						// sample error at each second, hand to driver
						phase_err           <= next_err;
						MOTOR_PHASE_ERR_OUT <= next_err;
						MOTOR_PHASE_STB_OUT <= 1'b1;
						phase_lock <= (err_abs <= `LRF_LOCK_TOL);
					end
					else if (!ctrl[`LRF_CTRL_LOCK_EN])
						phase_lock <= 1'b0;
				end
				default:
					state <= ST_STOP;
			endcase
		end
	end

	// laser firing, angle or time based, only while running
	always @(posedge REF_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			FIRE_OUT <= 1'b0;
			step_cnt <= 3'h0;
			fire_cnt <= 9'h0;
		end
		else if (state != ST_RUN)
		begin
			FIRE_OUT <= 1'b0;
			step_cnt <= 3'h0;
			fire_cnt <= 9'h0;
		end
		else if (ctrl[`LRF_CTRL_TRIG_TIME])
		begin
			step_cnt <= 3'h0;
			FIRE_OUT <= (fire_cnt == FIRE_LAST);
			fire_cnt <= (fire_cnt == FIRE_LAST) ? 9'h0 : fire_cnt + 9'h1;
		end
		else
		begin
			fire_cnt <= 9'h0;
			FIRE_OUT <= 1'b0;
			if (tick_rise)
			begin
				if (step_cnt >= fire_step(spin_fast) - 3'h1)
				begin
					FIRE_OUT <= 1'b1;
					step_cnt <= 3'h0;
				end
				else
					step_cnt <= step_cnt + 3'h1;
			end
		end
	end

	// point post-processing, one cycle latency
	always @(posedge REF_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			PT_VALID_OUT <= 1'b0;
			PT_DIST_OUT  <= 16'h0;
			PT_REFL_OUT  <= 8'h0;
			PT_MODE_OUT  <= `LRF_RET_RESET;
		end
		else
		begin
			PT_VALID_OUT <= PT_VALID_IN & ~(ctrl[`LRF_CTRL_FILTER] & PT_MIXED_IN);
			PT_MODE_OUT  <= ret_mode;
			if (PT_VALID_IN)
			begin
				PT_DIST_OUT <= PT_DIST_IN;
				PT_REFL_OUT <= ctrl[`LRF_CTRL_NONLIN] ? refl_curve(PT_REFL_IN)
				                                      : PT_REFL_IN;
			end
		end
	end

endmodule

// file: tb/lrf_top_checker.sv
// assertions on lrf_top ports, bound from the bench top file
// assumes apb writes commit when psel, penable and pready are all high
`timescale 1ns/1ps
module lrf_top_checker
(
	// clock, reset and apb
	input wire logic        REF_CLK_IN,
	input wire logic        RSTN_IN,
	input wire logic        PSEL_IN,
	input wire logic        PENABLE_IN,
	input wire logic        PWRITE_IN,
	input wire logic [7:0]  PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic        PREADY_OUT,
	// motor, laser and points
	input wire logic        MOTOR_EN_OUT,
	input wire logic        MOTOR_AT_SPEED_IN,
	input wire logic        MOTOR_FAST_OUT,
	input wire logic        MOTOR_PHASE_STB_OUT,
	input wire logic        FIRE_OUT,
	input wire logic        PT_VALID_IN,
	input wire logic        PT_MIXED_IN,
	input wire logic        PT_VALID_OUT,
	input wire logic [2:0]  PT_MODE_OUT
);
	logic [6:0] ctrl;  // control shadow
	logic [2:0] ret;   // return mode shadow
	logic [9:0] gap;   // clocks since last firing
	logic       tfire; // last firing was time based
	wire        wr = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (!RSTN_IN);
	// shadows follow committed writes; out of range modes ignored
	always @(posedge REF_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			ctrl <= 7'h00;
			ret <= 3'h3;
			gap <= 10'h000;
			tfire <= 1'h0;
		end
		else
		begin
			if (wr && PADDR_IN == 8'h00)
				ctrl <= PWDATA_IN[6:0];
			if (wr && PADDR_IN == 8'h04 && PWDATA_IN[2:0] < 3'h6)
				ret <= PWDATA_IN[2:0];
			gap <= FIRE_OUT ? 10'h000 : gap + {9'h000, gap != 10'h3FF};
			// a period is judged only between two time fires of one run
			tfire <= (FIRE_OUT || tfire) && ctrl[1] && !ctrl[4] && MOTOR_AT_SPEED_IN;
		end
	end
	sequence s_setup;
		PSEL_IN && !PENABLE_IN;
	endsequence
	sequence s_clean;
		PT_VALID_IN && !(ctrl[2] && PT_MIXED_IN);
	endsequence
	AST_READY: assert property (
		s_setup |=> PREADY_OUT) else $error("ready missing");
	AST_FAST: assert property (
		ctrl[0] == $past(ctrl[0]) && ctrl[0] == $past(ctrl[0], 2) |-> MOTOR_FAST_OUT == ctrl[0])
		else $error("spin rate wrong");
	AST_STANDBY: assert property (
		ctrl[4] && $past(ctrl[4]) && $past(ctrl[4], 2) |-> !MOTOR_EN_OUT && !FIRE_OUT)
		else $error("active in standby");
	AST_PULSE: assert property (
		FIRE_OUT |=> !FIRE_OUT) else $error("long firing pulse");
	AST_PERIOD: assert property (
		FIRE_OUT && tfire |-> gap == 10'h1F3) else $error("time period wrong");
	AST_PASS: assert property (
		s_clean |=> PT_VALID_OUT) else $error("point lost");
	AST_MODE: assert property (
		ret == $past(ret) |-> PT_MODE_OUT == ret) else $error("mode wrong");
	AST_STROBE: assert property (
		MOTOR_PHASE_STB_OUT |-> (ctrl[6] || $past(ctrl[6]) || $past(ctrl[6], 2))
		##1 !MOTOR_PHASE_STB_OUT) else $error("stray strobe");
endmodule

// file: tb/lrf_time_src.sv
// model of the gps receiver and ptp master giving second marks
// assumes the bench clock; one second lasts PERIOD clocks
`timescale 1ns/1ps
module lrf_time_src
#(
	parameter PERIOD = 2000
)
(
	input  wire logic clk_in,    // bench clock
	input  wire logic gps_on_in, // receiver locked
	input  wire logic ptp_on_in, // master tracked
	output logic      pps_out = 1'h0,
	output logic      gps_lock_out = 1'h0,
	output logic      ptp_sec_out = 1'h0,
	output logic      ptp_lock_out = 1'h0
);
	int cnt = 0; // clocks into the second
	// marks stay low while their source is unlocked
	always @(posedge clk_in)
	begin
		cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
		pps_out <= gps_on_in && cnt < 4;
		ptp_sec_out <= ptp_on_in && cnt > 699 && cnt < 704;
		gps_lock_out <= gps_on_in;
		ptp_lock_out <= ptp_on_in;
	end
endmodule

// file: tb/tb_top.sv
// bench of lrf_top: apb master, encoder, motor and point stimulus
// assumes a 100 ns clock and a second shortened to 2000 clocks
`timescale 1ns/1ps
module tb_top;
	logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, err;
	logic        gon = 0, pon = 0, enc = 0, idx = 0, spd = 0, pv = 0, pm = 0;
	logic [7:0]  pa = 8'h00, pr = 8'h00;
	logic [31:0] pwd = 32'h0, rd;
	wire  [31:0] prd;
	wire  [12:0] perr;
	wire  [15:0] dout;
	wire  [7:0]  rout;
	wire  [2:0]  mode;
	wire         rdy, slv, pps, glk, psec, plk, men, fast, stb, fire, vout;
	int          mismatches = 0, checks_done = 0, cyc = 0, fires = 0, f;
	int          pps_at = 0, psec_at = 0;
	logic        pps_q = 0, psec_q = 0;
	lrf_time_src #(.PERIOD(2000)) src (.clk_in(clk), .gps_on_in(gon), .ptp_on_in(pon),
		.pps_out(pps), .gps_lock_out(glk), .ptp_sec_out(psec), .ptp_lock_out(plk));
	lrf_top #(.SEC_CYCLES(2000)) uut (.REF_CLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
		.PREADY_OUT(rdy), .PSLVERR_OUT(slv), .PPS_IN(pps), .GPS_LOCK_IN(glk),
		.PTP_SEC_IN(psec), .PTP_LOCK_IN(plk), .ENC_TICK_IN(enc), .ENC_INDEX_IN(idx),
		.MOTOR_AT_SPEED_IN(spd), .MOTOR_EN_OUT(men), .MOTOR_FAST_OUT(fast),
		.MOTOR_PHASE_ERR_OUT(perr), .MOTOR_PHASE_STB_OUT(stb), .FIRE_OUT(fire),
		.PT_VALID_IN(pv), .PT_DIST_IN(16'h1234), .PT_REFL_IN(pr), .PT_MIXED_IN(pm),
		.PT_VALID_OUT(vout), .PT_DIST_OUT(dout), .PT_REFL_OUT(rout), .PT_MODE_OUT(mode));
	initial
		forever #50 clk = ~clk;
	// firing count and run limit
	always @(posedge clk)
	begin
		fires <= fires + (fire === 1'h1);
		cyc <= cyc + 1;
		pps_q <= pps;
		psec_q <= psec;
		// cycle of each second mark's rising edge
		if (pps === 1'h1 && pps_q !== 1'h1)
			pps_at <= cyc;
		if (psec === 1'h1 && psec_q !== 1'h1)
			psec_at <= cyc;
		if (cyc == 40000)
		begin
			mismatches++;
			give_verdict();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// one apb transfer, held until ready is sampled
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk) pen <= 1'h1;
		do @(posedge clk); while (rdy !== 1'h1);
		rd = prd;
		err = slv;
		psel <= 1'h0;
		pen <= 1'h0;
		@(posedge clk);
	endtask
	task automatic rdm(input string nm, input logic [7:0] a, input logic [31:0] m, e);
		apb(1'h0, a, 32'h0);
		chk(nm, e, rd & m);
	endtask
	task automatic tick(input int n);
		repeat (n)
		begin
			enc <= 1'h1;
			wt(4);
			enc <= 1'h0;
			wt(4);
		end
	endtask
	task automatic pt(input logic [7:0] r, input logic m, v, input logic [7:0] er);
		pv <= 1'h1;
		pr <= r;
		pm <= m;
		@(posedge clk) pv <= 1'h0;
		@(posedge clk);
		chk("valid", v, vout);
		if (v)
		begin
			chk("refl", er, rout);
			chk("dist", 32'h1234, dout);
		end
	endtask
	// waits for a strobe; src 1 or 2 checks it follows that mark by 3 clocks
	task automatic sec(input int src);
		int n = 0;
		while (stb !== 1'h1 && n < 4000)
		begin
			@(posedge clk);
			n++;
		end
		chk("second", 1'h1, stb);
		if (src == 1)
			chk("pps phase", 32'h3, cyc - pps_at);
		if (src == 2)
			chk("ptp phase", 32'h3, cyc - psec_at);
	endtask
	task automatic t_regs;
		rdm("ctrl", 8'h00, 32'hFFFFFFFF, 32'h0);
		rdm("mode", 8'h04, 32'hFFFFFFFF, 32'h3);
		rdm("rate", 8'h0C, 32'h7FF, 32'h258);
		rdm("hole", 8'h14, 32'hFFFFFFFF, 32'h0);
		chk("slverr", 1'h1, err);
		apb(1'h1, 8'h04, 32'h5);
		apb(1'h1, 8'h04, 32'h7);
		rdm("mode", 8'h04, 32'h7, 32'h5);
		apb(1'h1, 8'h08, 32'hF9F);
		apb(1'h1, 8'h08, 32'hFA0);
		rdm("angle", 8'h08, 32'hFFF, 32'hF9F);
	endtask
	task automatic t_points;
		for (int k = 0; k < 6; k++)
		begin
			apb(1'h1, 8'h04, k);
			pt(8'h10, 1'h0, 1'h1, 8'h10);
			chk("mode", k, mode);
		end
		pt(8'hC8, 1'h1, 1'h1, 8'hC8);
		apb(1'h1, 8'h00, 32'hC);
		pt(8'hC8, 1'h1, 1'h0, 8'h00);
		pt(8'h14, 1'h0, 1'h1, 8'h50);
		pt(8'h32, 1'h0, 1'h1, 8'h92);
		pt(8'hC8, 1'h0, 1'h1, 8'hDA);
		apb(1'h1, 8'h00, 32'h0);
	endtask
	task automatic t_fire;
		rdm("spinup", 8'h0C, 32'h30000, 32'h10000);
		spd <= 1'h1;
		wt(6);
		f = fires;
		tick(8);
		chk("slow", f + 4, fires);
		apb(1'h1, 8'h00, 32'h1);
		rdm("rate", 8'h0C, 32'h7FF, 32'h4B0);
		chk("fast", 1'h1, fast);
		f = fires;
		tick(8);
		chk("quick", f + 2, fires);
		apb(1'h1, 8'h00, 32'h2);
		wt(600);
		f = fires;
		wt(1500);
		chk("timed", f + 3, fires);
		apb(1'h1, 8'h00, 32'h0);
	endtask
	task automatic t_standby;
		apb(1'h1, 8'h00, 32'h10);
		wt(4);
		chk("motor", 1'h0, men);
		f = fires;
		tick(8);
		chk("idle", f, fires);
		spd <= 1'h0;
		apb(1'h1, 8'h00, 32'h0);
		wt(4);
		chk("motor", 1'h1, men);
		tick(8);
		chk("early", f, fires);
		spd <= 1'h1;
		wt(6);
		tick(8);
		chk("resume", f + 4, fires);
	endtask
	task automatic t_lock;
		idx <= 1'h1;
		wt(4);
		idx <= 1'h0;
		gon <= 1'h1;
		apb(1'h1, 8'h08, 32'h0);
		apb(1'h1, 8'h00, 32'h40);
		rdm("source", 8'h0C, 32'h180000, 32'h80000);
		sec(1);
		rdm("locked", 8'h0C, 32'h40000, 32'h40000);
		// ptp locks early so the source switch has no internal gap
		pon <= 1'h1;
		apb(1'h1, 8'h08, 32'hA);
		sec(1);
		chk("error", 13'h1FF6, perr);
		rdm("phase", 8'h10, 32'h1FFF, 32'h1FF6);
		apb(1'h1, 8'h00, 32'h60);
		rdm("source", 8'h0C, 32'h180000, 32'h100000);
		sec(2);
		gon <= 1'h0;
		pon <= 1'h0;
		wt(6);
		rdm("source", 8'h0C, 32'h180000, 32'h0);
		sec(0);
	endtask
	task automatic give_verdict;
		if (mismatches == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		rstn <= 1'h1;
		@(posedge clk);
		t_regs();
		t_points();
		t_fire();
		t_standby();
		t_lock();
		give_verdict();
	end
endmodule
bind lrf_top lrf_top_checker chk_i (.REF_CLK_IN, .RSTN_IN, .PSEL_IN, .PENABLE_IN,
	.PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PREADY_OUT, .MOTOR_EN_OUT, .MOTOR_FAST_OUT,
	.MOTOR_PHASE_STB_OUT, .FIRE_OUT, .PT_VALID_IN, .PT_MIXED_IN, .PT_VALID_OUT,
	.PT_MODE_OUT, .MOTOR_AT_SPEED_IN);
